// ==== logic/parallel_io_command_decoder.sv ====
// command decoder for the robot controller's parallel external inputs
// Summary of operation
// - accepted run request starts the program
// - halt input interrupts and holds robot stopped
// - polarity bit: 0 closed, 1 open halt
// - program reset clears program, alarm, powers servo
// - alarm clear clears alarm only
// - servo input toggles servo, brake follows
// - servo off: brake follows level input
// - cycle command toggles continuous/single mode
// - speed limit edge applies jog speed limit
// - enable request edge toggles external control
// - outputs clear edge drives general outputs off
// - program select edge latches numeric input
// - override edge latches override speed
// - report edges present value on numeric output
// - numeric input as four 4-bit groups
// - unconnected inputs read as off only if pulled low at the pad
// - level commands active while on, halt while off when polarity bit is 1
// - edge commands trigger on rising edge
// - running blocks reset, brake, clear, selects
// - most commands need external control enabled or the servo cut by the servo input
// - after halt ignore run, and servo unless the servo input had cut it
// - external control active output mirrors state
// - groups are binary, one or two wide
`timescale 1ns/10ps
module parallel_io_command_decoder (
	input wire logic pclk, // system clock, 100 MHz
	input wire logic presetn, // asynchronous reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction
	input wire logic [7:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic [15:0] cmd_in, // command inputs, see pkg cmd_idx_t
	input wire logic [15:0] numeric_in, // numeric input groups 0..3
	input wire logic program_done, // running program reached its end
	input wire logic [7:0] exec_line, // line currently executing
	output logic running, // program executing
	output logic halted, // stop held
	output logic alarm, // alarm present
	output logic servo_on, // servo power on
	output logic brake_released, // brakes released
	output logic cycle_continuous, // continuous mode
	output logic speed_limited, // jog speed limit in force
	output logic [15:0] speed_limit, // jog speeds while limited
	output logic external_control_active, // external equipment has control
	output logic [15:0] general_out, // general-purpose outputs
	output logic [15:0] numeric_out // numeric output groups
);
	logic [15:0] cmd_q, cmd_prev_q, rise;
	logic [15:0] num_q;
	logic [31:0] ctrl_q;
	logic [15:0] jog_q;
	logic [7:0] program_q, line_q, override_q;
	logic running_q, alarm_q, servo_q, brake_q, cycle_q, speed_q, ext_q;
	logic interrupted_q, halt_seen_q, servo_cut_q;
	logic [15:0] gen_q, numeric_q;
	pio_cmd_pkg::report_t rep_q;
	logic halt_now, gate_ext, run_ok, servo_ok, blk_run;
	logic [7:0] num_val;
	logic wr, rd;
	logic [31:0] rdata_d, rdata_q;

	// inputs sampled once; undriven pins must be pulled low at the pad
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_q <= 16'h0000;
			cmd_prev_q <= 16'h0000;
			num_q <= 16'h0000;
		end else begin
			cmd_q <= cmd_in;
			cmd_prev_q <= cmd_q;
			num_q <= numeric_in;
		end
	end

	// rising edges found before any gating
	genvar gi;
	generate
		for (gi = 0; gi < pio_cmd_pkg::num_cmds; gi++) begin : g_edge
			assign rise[gi] = cmd_q[gi] & ~cmd_prev_q[gi];
		end
	endgenerate

	// selected groups combine, group zero lowest, two groups give 0..255
	always_comb begin
		if (ctrl_q[pio_cmd_pkg::ctrl_grp_lsb +: 1])
			num_val = num_q[7:0];
		else
			num_val = {4'h0, num_q[3:0]};
	end

	// halt is a level, polarity chosen by software
	assign halt_now = cmd_q[pio_cmd_pkg::c_halt] ^ ctrl_q[pio_cmd_pkg::ctrl_polarity_bit];
	assign gate_ext = ext_q | servo_cut_q;
	assign blk_run = running_q;
	assign run_ok = gate_ext & (~halt_seen_q | servo_cut_q) & ~halt_now;
	assign servo_ok = gate_ext & (~halt_seen_q | servo_cut_q);

	// program state: start, halt, reset
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			running_q <= 1'b0;
			interrupted_q <= 1'b0;
			halt_seen_q <= 1'b0;
		end else begin
			if (halt_now) begin
				running_q <= 1'b0;
				interrupted_q <= running_q | interrupted_q;
				halt_seen_q <= 1'b1;
			end else if (rise[pio_cmd_pkg::c_run] & run_ok & servo_q & ~alarm_q) begin
				running_q <= 1'b1;
				halt_seen_q <= 1'b0;
			end else if (program_done) begin
				running_q <= 1'b0;
			end else if (rise[pio_cmd_pkg::c_prog_reset] & gate_ext & ~blk_run) begin
				interrupted_q <= 1'b0;
				halt_seen_q <= 1'b0;
			end
		end
	end

	// alarm: software set wins over clears
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_q <= 1'b0;
		end else if (wr && paddr == pio_cmd_pkg::ctrl_off
			&& pwdata[pio_cmd_pkg::ctrl_alarm_set_bit]) begin
			alarm_q <= 1'b1;
		end else if (rise[pio_cmd_pkg::c_prog_reset] & gate_ext & ~blk_run) begin
			alarm_q <= 1'b0;
		end else if (rise[pio_cmd_pkg::c_alarm] & gate_ext) begin
			alarm_q <= 1'b0;
		end
	end

	// servo and brake
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			servo_q <= 1'b0;
			servo_cut_q <= 1'b0;
			brake_q <= 1'b0;
		end else begin
			if (rise[pio_cmd_pkg::c_prog_reset] & gate_ext & ~blk_run & ~servo_q) begin
				servo_q <= 1'b1;
				servo_cut_q <= 1'b0;
				brake_q <= 1'b1;
			end else if (rise[pio_cmd_pkg::c_servo] & servo_ok) begin
				servo_q <= ~servo_q;
				servo_cut_q <= servo_q;
				brake_q <= ~servo_q;
			end else if (~servo_q) begin
				// level brake control only when idle and permitted
				if (gate_ext & ~blk_run)
					brake_q <= cmd_q[pio_cmd_pkg::c_brake];
				else
					brake_q <= 1'b0;
			end
		end
	end

	// modes and external control
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cycle_q <= 1'b0;
			speed_q <= 1'b0;
			ext_q <= 1'b0;
		end else begin
			if (rise[pio_cmd_pkg::c_cycle] & gate_ext)
				cycle_q <= ~cycle_q;
			if (rise[pio_cmd_pkg::c_speed])
				speed_q <= 1'b1;
			if (rise[pio_cmd_pkg::c_ext])
				ext_q <= ~ext_q;
		end
	end

	// latches of program, line and override
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			program_q <= 8'h00;
			line_q <= 8'h00;
			override_q <= pio_cmd_pkg::override_rst;
		end else begin
			if (rise[pio_cmd_pkg::c_pgn] & gate_ext & ~blk_run)
				program_q <= num_val;
			if (rise[pio_cmd_pkg::c_lln] & gate_ext & ~blk_run)
				line_q <= num_val;
			if (rise[pio_cmd_pkg::c_ovr] & gate_ext)
				override_q <= num_val;
		end
	end

	// general outputs: software writes, outputs clear forces off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			gen_q <= 16'h0000;
		end else if (rise[pio_cmd_pkg::c_outclr] & gate_ext & ~blk_run) begin
			gen_q <= 16'h0000;
		end else if (wr && paddr == pio_cmd_pkg::numeric_out_off) begin
			gen_q <= pwdata[31:16];
		end
	end

	// numeric reports
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			numeric_q <= pio_cmd_pkg::numeric_rst;
			rep_q <= pio_cmd_pkg::rep_none;
		end else if (rise[pio_cmd_pkg::c_pgr]) begin
			numeric_q <= {8'h00, program_q};
			rep_q <= pio_cmd_pkg::rep_program;
		end else if (rise[pio_cmd_pkg::c_llr]) begin
			numeric_q <= {8'h00, exec_line};
			rep_q <= pio_cmd_pkg::rep_line;
		end else if (rise[pio_cmd_pkg::c_orr]) begin
			numeric_q <= {8'h00, override_q};
			rep_q <= pio_cmd_pkg::rep_override;
		end else begin
			case (rep_q)
				pio_cmd_pkg::rep_line: numeric_q <= {8'h00, exec_line};
				default: numeric_q <= numeric_q;
			endcase
		end
	end

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_q <= pio_cmd_pkg::ctrl_rst;
			jog_q <= pio_cmd_pkg::jog_rst;
		end else if (wr) begin
			if (paddr == pio_cmd_pkg::ctrl_off)
				ctrl_q <= pwdata;
			if (paddr == pio_cmd_pkg::jog_off)
				jog_q <= pwdata[15:0];
		end
	end

	// apb slave, zero wait states
	assign wr = psel & penable & pwrite;
	assign rd = psel & ~pwrite;
	assign pready = 1'b1;
	always_comb begin
		pslverr = 1'b0;
		case (paddr)
			pio_cmd_pkg::ctrl_off: rdata_d = ctrl_q;
			pio_cmd_pkg::status_off: rdata_d = {22'h0, servo_cut_q, interrupted_q, ext_q,
				speed_q, cycle_q, brake_q, servo_q, alarm_q, halt_now, running_q};
			pio_cmd_pkg::program_off: rdata_d = {24'h0, program_q};
			pio_cmd_pkg::line_off: rdata_d = {24'h0, line_q};
			pio_cmd_pkg::override_off: rdata_d = {24'h0, override_q};
			pio_cmd_pkg::exec_line_off: rdata_d = {24'h0, exec_line};
			pio_cmd_pkg::numeric_out_off: rdata_d = {gen_q, numeric_q};
			pio_cmd_pkg::jog_off: rdata_d = {16'h0, jog_q};
			default: begin
				rdata_d = 32'h0;
				pslverr = psel & penable;
			end
		endcase
	end

	// read data captured in the setup cycle, so it stands through the access phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata_q <= 32'h0000_0000;
		end else if (rd & ~penable) begin
			rdata_q <= rdata_d;
		end
	end
	assign prdata = rdata_q;

	assign running = running_q;
	assign halted = halt_now;
	assign alarm = alarm_q;
	assign servo_on = servo_q;
	assign brake_released = brake_q;
	assign cycle_continuous = cycle_q;
	assign speed_limited = speed_q;
	assign speed_limit = speed_q ? jog_q : 16'h0000;
	assign external_control_active = ext_q;
	assign general_out = gen_q;
	assign numeric_out = numeric_q;

	// halt stops a run within one cycle
	halt_stops_run_a: assert property (@(posedge pclk) disable iff (!presetn)
		halt_now |=> !running_q) else $error("halt did not stop run");
	// external toggle follows edge
	ext_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
		rise[pio_cmd_pkg::c_ext] |=> ext_q != $past(ext_q)) else $error("ext not toggled");
	// no start without permission
	run_gated_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(running_q) |-> $past(run_ok)) else $error("start not gated");
	// program latch blocked while running
	prog_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		running_q |=> program_q == $past(program_q)) else $error("program changed");
	// outputs clear
	outs_cleared_a: assert property (@(posedge pclk) disable iff (!presetn)
		rise[pio_cmd_pkg::c_outclr] && gate_ext && !running_q |=> gen_q == 16'h0)
		else $error("outputs not cleared");
	// brake follows servo on
	brake_sync_a: assert property (@(posedge pclk) disable iff (!presetn)
		$rose(servo_q) |-> brake_q) else $error("brake not released with servo");
	// alarm clear
	alarm_clear_a: assert property (@(posedge pclk) disable iff (!presetn)
		rise[pio_cmd_pkg::c_alarm] && gate_ext && !wr |=> !alarm_q)
		else $error("alarm not cleared");
	// report program number
	report_prog_a: assert property (@(posedge pclk) disable iff (!presetn)
		rise[pio_cmd_pkg::c_pgr] |=> numeric_q[7:0] == $past(program_q))
		else $error("bad program report");
	// accepted start sets the robot running
	run_start_a: assert property (@(posedge pclk) disable iff (!presetn)
		rise[pio_cmd_pkg::c_run] && run_ok && servo_q && !alarm_q |=> running_q)
		else $error("start not taken");
	// halt of a running program leaves it interrupted
	run_interrupt_a: assert property (@(posedge pclk) disable iff (!presetn)
		halt_now && running_q |=> interrupted_q && !running_q)
		else $error("run not interrupted");
	// program reset clears the alarm and powers the servo
	prog_reset_a: assert property (@(posedge pclk) disable iff (!presetn)
		rise[pio_cmd_pkg::c_prog_reset] && gate_ext && !running_q && !wr
		&& !rise[pio_cmd_pkg::c_servo] |=> !alarm_q && servo_q)
		else $error("program reset lost");
	// alarm clear never powers the servo
	alarm_keeps_servo_a: assert property (@(posedge pclk) disable iff (!presetn)
		rise[pio_cmd_pkg::c_alarm] && !rise[pio_cmd_pkg::c_prog_reset] && !servo_q
		&& !rise[pio_cmd_pkg::c_servo] |=> !servo_q) else $error("alarm clear moved servo");
	// servo toggles with the brake in step
	servo_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
		rise[pio_cmd_pkg::c_servo] && servo_ok && !rise[pio_cmd_pkg::c_prog_reset]
		|=> servo_q != $past(servo_q) && brake_q == servo_q) else $error("servo not toggled");
	// servo off: brake follows its level input while permitted
	brake_level_a: assert property (@(posedge pclk) disable iff (!presetn)
		!servo_q && gate_ext && !running_q && !rise[pio_cmd_pkg::c_servo]
		&& !rise[pio_cmd_pkg::c_prog_reset] |=> brake_q == $past(cmd_q[pio_cmd_pkg::c_brake]))
		else $error("brake not following input");
	// cycle mode toggles per accepted edge
	cycle_toggle_a: assert property (@(posedge pclk) disable iff (!presetn)
		rise[pio_cmd_pkg::c_cycle] && gate_ext |=> cycle_q != $past(cycle_q))
		else $error("cycle mode not toggled");
	// speed limit edge sets the limit
	speed_set_a: assert property (@(posedge pclk) disable iff (!presetn)
		rise[pio_cmd_pkg::c_speed] |=> speed_q)
		else $error("speed limit not set");
	// program select latches the numeric value
	program_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
		rise[pio_cmd_pkg::c_pgn] && gate_ext && !running_q |=> program_q == $past(num_val))
		else $error("program not latched");
	// line select latches the numeric value
	line_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
		rise[pio_cmd_pkg::c_lln] && gate_ext && !running_q |=> line_q == $past(num_val))
		else $error("line not latched");
	// override latches the numeric value
	override_latch_a: assert property (@(posedge pclk) disable iff (!presetn)
		rise[pio_cmd_pkg::c_ovr] && gate_ext |=> override_q == $past(num_val))
		else $error("override not latched");
	// line latch blocked while running
	line_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		running_q |=> line_q == $past(line_q))
		else $error("line changed");
	// outputs clear ignored while running, only software may change them
	outs_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
		running_q && !wr |=> gen_q == $past(gen_q))
		else $error("outputs changed");
	// halt memory blocks the servo command
	servo_halt_block_a: assert property (@(posedge pclk) disable iff (!presetn)
		rise[pio_cmd_pkg::c_servo] && halt_seen_q && !servo_cut_q
		&& !rise[pio_cmd_pkg::c_prog_reset] |=> servo_q == $past(servo_q))
		else $error("servo taken after halt");
	// override report presents the override value
	report_override_a: assert property (@(posedge pclk) disable iff (!presetn)
		rise[pio_cmd_pkg::c_orr] && !rise[pio_cmd_pkg::c_pgr] && !rise[pio_cmd_pkg::c_llr]
		|=> numeric_q[7:0] == $past(override_q)) else $error("bad override report");
endmodule

// ==== logic/pio_cmd_pkg.sv ====
// shared constants, register map and types for the parallel command decoder
package pio_cmd_pkg;
	// register byte offsets
	localparam logic [7:0] ctrl_off = 8'h00;
	localparam logic [7:0] status_off = 8'h04;
	localparam logic [7:0] program_off = 8'h08;
	localparam logic [7:0] line_off = 8'h0c;
	localparam logic [7:0] override_off = 8'h10;
	localparam logic [7:0] exec_line_off = 8'h14;
	localparam logic [7:0] numeric_out_off = 8'h18;
	localparam logic [7:0] jog_off = 8'h1c;
	// ctrl field positions
	localparam int ctrl_polarity_bit = 0;
	localparam int ctrl_running_bit = 1;
	localparam int ctrl_alarm_set_bit = 2;
	localparam int ctrl_grp_lsb = 4;
	// status field positions
	localparam int st_running_bit = 0;
	localparam int st_halted_bit = 1;
	localparam int st_alarm_bit = 2;
	localparam int st_servo_bit = 3;
	localparam int st_brake_bit = 4;
	localparam int st_cycle_bit = 5;
	localparam int st_speed_lim_bit = 6;
	localparam int st_ext_bit = 7;
	localparam int st_interrupted_bit = 8;
	localparam int st_servo_cut_bit = 9;
	// reset values
	localparam logic [31:0] ctrl_rst = 32'h0000_0020;
	localparam logic [15:0] jog_rst = 16'h0a0a;
	localparam logic [15:0] numeric_rst = 16'h0000;
	localparam logic [7:0] override_rst = 8'h64;
	// timing: minimum edge-command pulse width
	localparam int pulse_min_ms = 100;
	localparam int clk_mhz = 100;
	localparam int pulse_min_cycles = pulse_min_ms * 1000 * clk_mhz;
	localparam int num_cmds = 16;
	localparam int num_outputs = 16;

	// one-hot command vector positions
	typedef enum int {
		c_run = 0, c_halt = 1, c_prog_reset = 2, c_alarm = 3, c_servo = 4,
		c_brake = 5, c_cycle = 6, c_speed = 7, c_ext = 8, c_outclr = 9,
		c_pgn = 10, c_pgr = 11, c_lln = 12, c_llr = 13, c_ovr = 14, c_orr = 15
	} cmd_idx_t;

	typedef struct packed {
		logic [3:0] g3;
		logic [3:0] g2;
		logic [3:0] g1;
		logic [3:0] g0;
	} numeric_t;

	typedef enum logic [1:0] {
		rep_none = 2'b00,
		rep_program = 2'b01,
		rep_line = 2'b11,
		rep_override = 2'b10
	} report_t;
endpackage

// ==== tb/plc_model.sv ====
// external control equipment driving the command and numeric inputs
`timescale 1ns/10ps
module plc_model #(
	parameter int hold = 4
) (
	input wire logic pclk, // system clock
	output logic [15:0] cmd_in, // command lines
	output logic [15:0] numeric_in // numeric groups
);
	initial begin
		cmd_in = '0;
		numeric_in = '0;
	end
	task automatic set_cmd(input int idx, input logic v);
		cmd_in[idx] <= v;
		@(posedge pclk);
	endtask
	// data is placed first and held as a level while the command pulses
	task automatic pulse(input int idx, input logic [15:0] v);
		numeric_in <= v;
		@(posedge pclk);
		set_cmd(idx, 1'b1);
		repeat (hold) @(posedge pclk);
		set_cmd(idx, 1'b0);
		repeat (hold) @(posedge pclk);
	endtask
endmodule

// ==== tb/tb_parallel_io_command_decoder.sv ====
// self-checking bench for the parallel command decoder
`timescale 1ns/10ps
module tb_parallel_io_command_decoder;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, program_done, err;
	logic [7:0] paddr, exec_line;
	logic [31:0] pwdata, prdata, rd;
	logic [15:0] cmd_in;
	logic [15:0] numeric_in, speed_limit, general_out, numeric_out;
	logic running, halted, alarm, servo_on, brake_released;
	logic cycle_continuous, speed_limited, external_control_active;
	int miscompares = 0;
	int checks_done = 0;
	parallel_io_command_decoder i_parallel_io_command_decoder (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .cmd_in(cmd_in),
		.numeric_in(numeric_in), .program_done(program_done), .exec_line(exec_line),
		.running(running), .halted(halted), .alarm(alarm), .servo_on(servo_on),
		.brake_released(brake_released), .cycle_continuous(cycle_continuous),
		.speed_limited(speed_limited), .speed_limit(speed_limit),
		.external_control_active(external_control_active), .general_out(general_out),
		.numeric_out(numeric_out));
	plc_model i_plc_model (.pclk(pclk), .cmd_in(cmd_in), .numeric_in(numeric_in));
	initial begin
		pclk = 0;
		forever #5 pclk = ~pclk;
	end
	task automatic conclude();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		if (pready !== 1'b1) begin
			miscompares++;
			conclude();
		end else begin
			rd = prdata;
			err = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge pclk);
		end
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0);
		chk(rd, exp);
	endtask
	initial begin
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = '0;
		pwdata = '0;
		program_done = 0;
		exec_line = 8'h3c;
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rdchk(pio_cmd_pkg::ctrl_off, pio_cmd_pkg::ctrl_rst);
		rdchk(pio_cmd_pkg::override_off, 32'(pio_cmd_pkg::override_rst));
		rdchk(pio_cmd_pkg::jog_off, 32'(pio_cmd_pkg::jog_rst));
		apb(1'b0, 8'h20, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		$display("reset and map done");
		i_plc_model.pulse(8, 16'h0);
		chk(external_control_active, 1'b1);
		i_plc_model.pulse(6, 16'h0);
		chk(cycle_continuous, 1'b1);
		apb(1'b1, pio_cmd_pkg::ctrl_off, 32'h30);
		i_plc_model.pulse(10, 16'h00a5);
		rdchk(pio_cmd_pkg::program_off, 32'ha5);
		i_plc_model.pulse(14, 16'h0032);
		rdchk(pio_cmd_pkg::override_off, 32'h32);
		i_plc_model.pulse(12, 16'h0017);
		rdchk(pio_cmd_pkg::line_off, 32'h17);
		i_plc_model.pulse(11, 16'h0);
		chk(numeric_out[7:0], 8'ha5);
		i_plc_model.pulse(13, 16'h0);
		chk(numeric_out[7:0], 8'h3c);
		i_plc_model.pulse(15, 16'h0);
		chk(numeric_out[7:0], 8'h32);
		apb(1'b1, pio_cmd_pkg::ctrl_off, 32'h20);
		i_plc_model.pulse(14, 16'h00f9);
		rdchk(pio_cmd_pkg::override_off, 32'h09);
		$display("latch and report done");
		apb(1'b1, pio_cmd_pkg::ctrl_off, 32'h34);
		apb(1'b1, pio_cmd_pkg::ctrl_off, 32'h30);
		chk(alarm, 1'b1);
		i_plc_model.pulse(3, 16'h0);
		chk({alarm, servo_on}, 2'b00);
		apb(1'b1, pio_cmd_pkg::ctrl_off, 32'h34);
		apb(1'b1, pio_cmd_pkg::ctrl_off, 32'h30);
		i_plc_model.pulse(2, 16'h0);
		chk({alarm, servo_on}, 2'b01);
		i_plc_model.pulse(0, 16'h0);
		chk(running, 1'b1);
		i_plc_model.pulse(10, 16'h0077);
		rdchk(pio_cmd_pkg::program_off, 32'ha5);
		$display("alarm and run done");
		i_plc_model.set_cmd(1, 1'b1);
		repeat (4) @(posedge pclk);
		chk({running, halted}, 2'b01);
		i_plc_model.set_cmd(1, 1'b0);
		repeat (4) @(posedge pclk);
		chk(halted, 1'b0);
		i_plc_model.pulse(0, 16'h0);
		chk(running, 1'b0);
		i_plc_model.pulse(4, 16'h0);
		chk(servo_on, 1'b1);
		apb(1'b1, pio_cmd_pkg::ctrl_off, 32'h31);
		@(posedge pclk);
		chk(halted, 1'b1);
		apb(1'b1, pio_cmd_pkg::ctrl_off, 32'h30);
		$display("halt done");
		apb(1'b1, pio_cmd_pkg::numeric_out_off, 32'habcd0000);
		@(posedge pclk);
		chk(general_out, 16'habcd);
		i_plc_model.pulse(9, 16'h0);
		chk(general_out, 16'h0);
		i_plc_model.pulse(8, 16'h0);
		chk(external_control_active, 1'b0);
		i_plc_model.pulse(6, 16'h0);
		chk(cycle_continuous, 1'b1);
		i_plc_model.pulse(8, 16'h0);
		i_plc_model.pulse(2, 16'h0);
		i_plc_model.pulse(4, 16'h0);
		chk({servo_on, brake_released}, 2'b00);
		i_plc_model.pulse(8, 16'h0);
		i_plc_model.pulse(6, 16'h0);
		chk(cycle_continuous, 1'b0);
		i_plc_model.set_cmd(5, 1'b1);
		repeat (4) @(posedge pclk);
		chk(brake_released, 1'b1);
		i_plc_model.set_cmd(5, 1'b0);
		repeat (4) @(posedge pclk);
		chk(brake_released, 1'b0);
		chk({speed_limited, speed_limit}, 17'h0);
		i_plc_model.pulse(7, 16'h0);
		chk({speed_limited, speed_limit}, {1'b1, pio_cmd_pkg::jog_rst});
		$display("outputs and gating done");
		conclude();
	end
endmodule
